// file: shared/pcfcr_pkg.sv
package pcfcr_pkg;
	// Attribute-space decode: high address bit selects the function registers
	localparam int          ADDR_W          = 26;
	localparam int          ADDR_SEL_BIT    = 25;
	localparam logic [25:0] OFS_CONFIG_OPT  = 26'h2000000;
	localparam logic [25:0] OFS_CFG_STATUS  = 26'h2000002;
	localparam logic [25:0] OFS_PIN_REPLACE = 26'h2000004;
	localparam logic [25:0] OFS_SOCKET_COPY = 26'h2000006;
	localparam logic [25:0] OFS_IO_EVENT    = 26'h2000008;
	// Field positions
	localparam int COR_SOFT_RESET   = 7;
	localparam int COR_LEVEL_IRQ    = 6;
	localparam int CSR_CHANGED      = 7;
	localparam int CSR_STS_ENABLE   = 6;
	localparam int CSR_BELL_ROUTE   = 4;
	localparam int CSR_LOW_POWER    = 2;
	localparam int CSR_IRQ          = 1;
	localparam int PRR_READY_CHG    = 5;
	localparam int PRR_READY_VAL    = 1;
	localparam int IO_EVENT_BELL_EVENT  = 4;
	localparam int IO_EVENT_BELL_ENABLE = 0;
	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Ready recovery after soft reset, in cycles
	localparam int READY_LOW_CYCLES = 4;
	// Host-side controller registers over AXI4-Lite
	localparam logic [7:0] HOST_CMD_OFS  = 8'h00;
	localparam logic [7:0] HOST_WDAT_OFS = 8'h04;
	localparam logic [7:0] HOST_STAT_OFS = 8'h08;
	localparam logic [1:0] AXI_OKAY      = 2'h0;
	localparam logic [1:0] AXI_SLVERR    = 2'h2;
	// Host status word: busy flag, ready-low flag, status-change-asserted flag
	localparam int STAT_BUSY_BIT = 10;
	localparam int STAT_NRDY_BIT = 9;
	localparam int STAT_CHG_BIT  = 8;
	typedef enum logic [2:0] {
		PCFCR_IDLE  = 3'h1,
		PCFCR_STRB  = 3'h2,
		PCFCR_DONE  = 3'h4
	} pcfcr_state_type;
endpackage

// file: shared/pcfcr_if.sv
`timescale 1ns/1ns
interface pcfcr_if;
	logic [25:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        reg_sel_n;
	logic        oe_n;
	logic        we_n;
	logic        card_hard_reset_pin;
	logic        phone_bell_input_n;
	logic        ready;
	logic        stschg_n;
	logic        ireq_n;
	modport card (
		input  addr, wdata, reg_sel_n, oe_n, we_n, card_hard_reset_pin, phone_bell_input_n,
		output rdata, ready, stschg_n, ireq_n
	);
	modport host (
		output addr, wdata, reg_sel_n, oe_n, we_n, card_hard_reset_pin,
		input  rdata, ready, stschg_n, ireq_n, phone_bell_input_n
	);
endinterface

// file: verilog/pcfcr_card.sv
// What this block does
// - Five registers, even addresses, only with A25 high
// - Registers work without the system clock
// - Soft reset bit holds card reset
// - Clearing soft reset drops then restores ready
// - Level select: zero pulse, one level
// - Configuration index zero means memory-only pinout
// - Changed set by ready change or enabled bell
// - Changed-driven status output needs enable and I/O configuration
// - Without routing, status follows changed when enabled
// - Routing drives status low while bell low
// - Low power bit enters and exits low power
// - Low power bit cleared by bell input
// - Host clears low power before other access
// - Interrupt bit read-only, shows pending request
// - Ready change sets flag; write needs bit one
// - Read ready level; write bit enables flag
// - Socket copy byte is plain read/write
// - Bell rising edge sets bell event flag
// - Bell path and status work in stop
// - Bell edge sets changed only when enabled
// - Low power gates clocks; osc halt stops oscillator
`timescale 1ns/1ns
module pcfcr_card
	import pcfcr_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic reset,
	pcfcr_if.card     bus,
	input  wire logic irq_pending,
	input  wire logic low_power_on,
	input  wire logic osc_halt,
	input  wire logic core_ready,
	output logic      core_reset,
	output logic      clocks_gated,
	output logic      oscillator_stop,
	output logic      memory_only_pinout,
	output logic      level_irq_mode,
	output logic [5:0] config_index
);
	logic [7:0] config_option;
	logic       changed_flag;
	logic       status_change_enable;
	logic       bell_routes_status;
	logic       low_power_request;
	logic       ready_changed_flag;
	logic [7:0] socket_copy;
	logic       bell_edge_event;
	logic       bell_edge_enable;
	logic [1:0] bell_sync;
	logic       bell_prev;
	logic [1:0] irq_sync;
	logic       irq_prev;
	logic [1:0] sel_sync;
	logic [1:0] we_sync;
	logic [1:0] oe_sync;
	logic       we_prev;
	logic [7:0] wdata_q;
	logic [25:0] addr_q;
	logic       ready_q;
	logic       ready_prev;
	logic [2:0] ready_cnt;
	logic       soft_prev;
	logic       bell_rise;
	logic       wr_strobe;
	logic       hit;

	// Pin synchronisers; strobes pass two flops before use
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bell_sync <= 2'h3;
			irq_sync  <= 2'h0;
			sel_sync  <= 2'h3;
			we_sync   <= 2'h3;
			oe_sync   <= 2'h3;
		end else begin
			bell_sync <= {bell_sync[0], bus.phone_bell_input_n};
			irq_sync  <= {irq_sync[0], irq_pending};
			sel_sync  <= {sel_sync[0], bus.reg_sel_n};
			we_sync   <= {we_sync[0], bus.we_n};
			oe_sync   <= {oe_sync[0], bus.oe_n};
		end
	end

	// Edge history, latched address and data
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bell_prev <= 1'b1;
			we_prev   <= 1'b1;
			irq_prev  <= 1'b0;
			addr_q    <= 26'h0000000;
			wdata_q   <= 8'h00;
		end else begin
			bell_prev <= bell_sync[1];
			we_prev   <= we_sync[1];
			irq_prev  <= irq_sync[1];
			addr_q    <= bus.addr;
			wdata_q   <= bus.wdata;
		end
	end

	// Decode: attribute select, A25 high, even address
	assign hit       = !sel_sync[1] && addr_q[ADDR_SEL_BIT] && !addr_q[0];
	assign wr_strobe = hit && !we_sync[1] && we_prev;
	assign bell_rise = bell_sync[1] && !bell_prev;

	// Configuration option register; hard reset pin clears all
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			config_option <= RESET_BYTE;
		end else if (bus.card_hard_reset_pin) begin
			config_option <= RESET_BYTE;
		end else if (wr_strobe && addr_q == OFS_CONFIG_OPT) begin
			config_option <= wdata_q;
		end
	end

	// Card status register controls and low power bit
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			status_change_enable <= 1'b0;
			bell_routes_status   <= 1'b0;
			low_power_request    <= 1'b0;
		end else if (bus.card_hard_reset_pin) begin
			status_change_enable <= 1'b0;
			bell_routes_status   <= 1'b0;
			low_power_request    <= 1'b0;
		end else begin
			if (wr_strobe && addr_q == OFS_CFG_STATUS) begin
				status_change_enable <= wdata_q[CSR_STS_ENABLE];
				bell_routes_status   <= wdata_q[CSR_BELL_ROUTE];
				low_power_request    <= wdata_q[CSR_LOW_POWER];
			end
			if (!bell_sync[1]) begin
				low_power_request <= 1'b0;
			end
		end
	end

	// Event flags; hardware set wins over host clear
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			changed_flag       <= 1'b0;
			ready_changed_flag <= 1'b0;
			bell_edge_event    <= 1'b0;
			bell_edge_enable   <= 1'b0;
		end else if (bus.card_hard_reset_pin) begin
			changed_flag       <= 1'b0;
			ready_changed_flag <= 1'b0;
			bell_edge_event    <= 1'b0;
			bell_edge_enable   <= 1'b0;
		end else begin
			if (wr_strobe && addr_q == OFS_CFG_STATUS) begin
				changed_flag <= wdata_q[CSR_CHANGED];
			end
			if (wr_strobe && addr_q == OFS_PIN_REPLACE && wdata_q[PRR_READY_VAL]) begin
				ready_changed_flag <= wdata_q[PRR_READY_CHG];
			end
			if (wr_strobe && addr_q == OFS_IO_EVENT) begin
				bell_edge_event  <= wdata_q[IO_EVENT_BELL_EVENT];
				bell_edge_enable <= wdata_q[IO_EVENT_BELL_ENABLE];
			end
			if (ready_q != ready_prev) begin
				ready_changed_flag <= 1'b1;
				changed_flag       <= 1'b1;
			end
			if (bell_rise) begin
				bell_edge_event <= 1'b1;
				if (bell_edge_enable) begin
					changed_flag <= 1'b1;
				end
			end
		end
	end

	// Socket copy byte
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			socket_copy <= RESET_BYTE;
		end else if (wr_strobe && addr_q == OFS_SOCKET_COPY) begin
			socket_copy <= wdata_q;
		end
	end

	// Ready: drop for a while once soft reset is released
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			soft_prev  <= 1'b0;
			ready_cnt  <= 3'h0;
			ready_q    <= 1'b0;
			ready_prev <= 1'b0;
		end else begin
			soft_prev  <= config_option[COR_SOFT_RESET];
			ready_prev <= ready_q;
			if (soft_prev && !config_option[COR_SOFT_RESET]) begin
				ready_cnt <= 3'(READY_LOW_CYCLES);
			end else if (ready_cnt != 3'h0) begin
				ready_cnt <= ready_cnt - 3'h1;
			end
			ready_q <= core_ready && !core_reset && ready_cnt == 3'h0 && !low_power_request;
		end
	end

	// Read data path
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bus.rdata <= 8'h00;
		end else if (hit && !oe_sync[1]) begin
			unique case (addr_q)
				OFS_CONFIG_OPT:  bus.rdata <= config_option;
				OFS_CFG_STATUS:  bus.rdata <= {changed_flag, status_change_enable, 1'b0,
					bell_routes_status, 1'b0, low_power_request, irq_sync[1], 1'b0};
				OFS_PIN_REPLACE: bus.rdata <= {2'h0, ready_changed_flag, 3'h0, ready_q, 1'b0};
				OFS_SOCKET_COPY: bus.rdata <= socket_copy;
				OFS_IO_EVENT:    bus.rdata <= {3'h0, bell_edge_event, 3'h0, bell_edge_enable};
				default:         bus.rdata <= 8'h00;
			endcase
		end else begin
			bus.rdata <= 8'h00;
		end
	end

	// Core side controls
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			core_reset      <= 1'b1;
			clocks_gated    <= 1'b0;
			oscillator_stop <= 1'b0;
		end else begin
			core_reset      <= bus.card_hard_reset_pin || config_option[COR_SOFT_RESET];
			clocks_gated    <= low_power_request && low_power_on;
			oscillator_stop <= low_power_request && low_power_on && osc_halt;
		end
	end

	// Mode outputs and status-change pin
	assign config_index       = config_option[5:0];
	assign memory_only_pinout = config_index == 6'h00;
	assign level_irq_mode     = config_option[COR_LEVEL_IRQ];
	assign bus.ready          = ready_q;
	// Level mode follows the request; pulse mode gives one low cycle per new request
	assign bus.ireq_n         = level_irq_mode ? !irq_sync[1]
		: !(irq_sync[1] && !irq_prev);
	// logic runs on a free clock kept alive in power down
	always_comb begin
		if (bell_routes_status) begin
			bus.stschg_n = bell_sync[1];
		end else begin
			bus.stschg_n = !(status_change_enable && changed_flag && !memory_only_pinout);
		end
	end
endmodule

// file: verilog/pcfcr_host.sv
`timescale 1ns/1ns
module pcfcr_host
	import pcfcr_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	pcfcr_if.host            bus,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	pcfcr_state_type state;
	logic [7:0]  aw_q;
	logic        aw_ok;
	logic [31:0] w_q;
	logic        w_ok;
	logic [31:0] cmd;
	logic [7:0]  wbyte;
	logic [7:0]  rbyte;
	logic        busy;
	logic        go;
	logic [1:0]  st_sync;
	logic [1:0] rdy_sync;
	logic [2:0]  cnt;

	// Pin synchronisers
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_sync  <= 2'h3;
			rdy_sync <= 2'h0;
		end else begin
			st_sync  <= {st_sync[0], bus.stschg_n};
			rdy_sync <= {rdy_sync[0], bus.ready};
		end
	end

	// AXI write channels, taken in either order
	assign s_axi_awready = !aw_ok && !s_axi_bvalid;
	assign s_axi_wready  = !w_ok && !s_axi_bvalid;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			aw_ok        <= 1'b0;
			w_ok         <= 1'b0;
			aw_q         <= 8'h00;
			w_q          <= 32'h00000000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= AXI_OKAY;
			cmd          <= 32'h00000000;
			wbyte        <= 8'h00;
			go           <= 1'b0;
		end else begin
			go <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok <= 1'b1;
				aw_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok <= 1'b1;
				w_q  <= s_axi_wdata;
			end
			if (aw_ok && w_ok) begin
				aw_ok        <= 1'b0;
				w_ok         <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= AXI_OKAY;
				if (aw_q == HOST_CMD_OFS && !busy) begin
					cmd <= w_q;
					go  <= 1'b1;
				end else if (aw_q == HOST_WDAT_OFS) begin
					wbyte <= w_q[7:0];
				end else if (aw_q != HOST_STAT_OFS || busy) begin
					s_axi_bresp <= AXI_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Card access: command bit 31 write, bits 25:0 address
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state         <= PCFCR_IDLE;
			cnt           <= 3'h0;
			rbyte         <= 8'h00;
			bus.addr      <= 26'h0000000;
			bus.wdata     <= 8'h00;
			bus.reg_sel_n <= 1'b1;
			bus.oe_n      <= 1'b1;
			bus.we_n      <= 1'b1;
		end else begin
			unique case (state)
				PCFCR_IDLE: begin
					if (go) begin
						bus.addr      <= cmd[25:0];
						bus.wdata     <= wbyte;
						bus.reg_sel_n <= 1'b0;
						cnt           <= 3'h0;
						state         <= PCFCR_STRB;
					end
				end
				PCFCR_STRB: begin
					cnt <= cnt + 3'h1;
					if (cnt == 3'h1) begin
						bus.we_n <= !cmd[31];
						bus.oe_n <= cmd[31];
					end
					if (cnt == 3'h6) begin
						rbyte    <= bus.rdata;
						bus.we_n <= 1'b1;
						bus.oe_n <= 1'b1;
						state    <= PCFCR_DONE;
					end
				end
				PCFCR_DONE: begin
					cnt <= cnt + 3'h1;
					if (cnt == 3'h7) begin
						bus.reg_sel_n <= 1'b1;
						state         <= PCFCR_IDLE;
					end
				end
			endcase
		end
	end
	assign busy = state != PCFCR_IDLE || go;
	assign bus.card_hard_reset_pin = cmd[30];

	// AXI read channel; status holds busy, ready, status-change, last byte
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= AXI_OKAY;
			unique case (s_axi_araddr)
				HOST_CMD_OFS:  s_axi_rdata <= cmd;
				HOST_WDAT_OFS: s_axi_rdata <= {24'h000000, wbyte};
				HOST_STAT_OFS: s_axi_rdata <= {21'h0, busy, !rdy_sync[1], !st_sync[1],
					rbyte};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= AXI_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// file: tb/pcfcr_link_sva.sv
`timescale 1ns/1ns
module pcfcr_link_sva
	import pcfcr_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        reset,
	input wire logic [25:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic [7:0]  rdata,
	input wire logic        reg_sel_n,
	input wire logic        oe_n,
	input wire logic        we_n,
	input wire logic        card_hard_reset_pin,
	input wire logic        phone_bell_input_n,
	input wire logic        ready,
	input wire logic        stschg_n,
	input wire logic        ireq_n
);
	logic [7:0] config_option_reg, card_cfg_status_reg, socket_copy_reg;
	wire logic  wr_sel = !we_n && !reg_sel_n;
	wire logic  rd_sel = !oe_n && !reg_sel_n;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	// Shadow of the configuration bytes seen on the link
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			config_option_reg <= 8'h00;
			card_cfg_status_reg <= 8'h00;
		end else if (card_hard_reset_pin) begin
			config_option_reg <= 8'h00;
			card_cfg_status_reg <= 8'h00;
		end else if (wr_sel && addr == OFS_CONFIG_OPT) begin
			config_option_reg <= wdata;
		end else if (wr_sel && addr == OFS_CFG_STATUS) begin
			card_cfg_status_reg <= wdata;
		end
	end
	// Shadow of the scratch byte
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			socket_copy_reg <= 8'h00;
		end else if (wr_sel && addr == OFS_SOCKET_COPY) begin
			socket_copy_reg <= wdata;
		end
	end
	property p_refused;
		(rd_sel && (!addr[ADDR_SEL_BIT] || addr[0]))[*4] |-> rdata == 8'h00;
	endproperty
	a_refused: assert property (p_refused) else $error("refused read gave data");
	property p_idle;
		oe_n[*6] |-> rdata == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("data left on idle bus");
	property p_scr;
		(rd_sel && addr == OFS_SOCKET_COPY)[*4] |-> rdata == socket_copy_reg;
	endproperty
	a_scr: assert property (p_scr) else $error("scratch byte lost");
	property p_pin_reset;
		card_hard_reset_pin[*8] |-> !ready;
	endproperty
	a_pin_reset: assert property (p_pin_reset) else $error("ready during pin reset");
	property p_ready_back;
		$fell(card_hard_reset_pin) |-> ##[1:40] ready;
	endproperty
	a_ready_back: assert property (p_ready_back) else $error("ready not restored");
	property p_route;
		(card_cfg_status_reg[CSR_BELL_ROUTE] && !phone_bell_input_n)[*8] |-> !stschg_n;
	endproperty
	a_route: assert property (p_route) else $error("bell not routed");
	property p_quiet;
		(!card_cfg_status_reg[CSR_BELL_ROUTE] && !card_cfg_status_reg[CSR_STS_ENABLE])[*8] |-> stschg_n;
	endproperty
	a_quiet: assert property (p_quiet) else $error("status change while disabled");
	property p_mem_only;
		(!card_cfg_status_reg[CSR_BELL_ROUTE] && config_option_reg[5:0] == 6'h00)[*8] |-> stschg_n;
	endproperty
	a_mem_only: assert property (p_mem_only) else $error("status change in memory mode");
endmodule

// file: tb/test_pc_card_function_config_regs.sv
`timescale 1ns/1ns
module test_pc_card_function_config_regs
	import pcfcr_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        irq_pending = 1'b0;
	logic        low_power_on = 1'b0;
	logic        osc_halt = 1'b0;
	logic        core_ready = 1'b1;
	logic        bell_n = 1'b1;
	logic        hard_pin = 1'b0;
	logic        core_reset, clocks_gated, oscillator_stop, memory_only_pinout, level_irq_mode;
	logic [5:0]  config_index;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, q, v;
	logic [31:0] wdata = 32'h0, rdata, word;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	int          err_count = 0;
	int          check_count = 0;
	int          rises = 0;
	pcfcr_if link();
	assign link.phone_bell_input_n = bell_n;
	always #25 ref_clk = ~ref_clk;
	always @(posedge link.ready) rises++;
	pcfcr_card i_pcfcr_card (.ref_clk(ref_clk), .reset(reset), .bus(link.card),
		.irq_pending(irq_pending), .low_power_on(low_power_on), .osc_halt(osc_halt),
		.core_ready(core_ready), .core_reset(core_reset), .clocks_gated(clocks_gated),
		.oscillator_stop(oscillator_stop), .memory_only_pinout(memory_only_pinout),
		.level_irq_mode(level_irq_mode), .config_index(config_index));
	pcfcr_host i_pcfcr_host (.ref_clk(ref_clk), .reset(reset), .bus(link.host),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	pcfcr_link_sva i_sva (.ref_clk(ref_clk), .reset(reset), .addr(link.addr),
		.wdata(link.wdata), .rdata(link.rdata), .reg_sel_n(link.reg_sel_n), .oe_n(link.oe_n),
		.we_n(link.we_n), .card_hard_reset_pin(link.card_hard_reset_pin),
		.phone_bell_input_n(link.phone_bell_input_n), .ready(link.ready),
		.stschg_n(link.stschg_n), .ireq_n(link.ireq_n));
	// Expected status-change level
	function automatic logic sts_n(logic rt, logic en, logic chg, logic io, logic b);
		return !((rt && !b) || (en && chg && io));
	endfunction
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] r);
		int n = 0;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		chk("bvalid", bvalid, 1'b1);
		bready <= 1'b0;
		chk("bresp", bresp, r);
	endtask
	task automatic axr(logic [7:0] a, output logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		chk("rvalid", rvalid, 1'b1);
		d = rdata;
		rready <= 1'b0;
	endtask
	// One card access through the host, result byte left in q
	task automatic op(bit w, logic [25:0] a, logic [7:0] d);
		logic [31:0] s;
		int n = 0;
		if (w) axw(HOST_WDAT_OFS, {24'h0, d}, AXI_OKAY);
		axw(HOST_CMD_OFS, {w, hard_pin, 4'h0, a}, AXI_OKAY);
		tick(2);
		do begin
			axr(HOST_STAT_OFS, s);
			n++;
		end while (s[STAT_BUSY_BIT] !== 1'b0 && n < 60);
		chk("busy", s[STAT_BUSY_BIT], 1'b0);
		q = s[7:0];
		word = s;
		tick(8);
	endtask
	task automatic wr(logic [25:0] a, logic [7:0] d);
		op(1'b1, a, d);
	endtask
	task automatic rd(string nm, logic [25:0] a, logic [7:0] e);
		op(1'b0, a, 8'h00);
		chk(nm, q, e);
	endtask
	task automatic ring();
		bell_n <= 1'b0;
		tick(10);
		bell_n <= 1'b1;
		tick(10);
	endtask
	task automatic wait_ready();
		int n = 0;
		while (link.ready !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		chk("ready", link.ready, 1'b1);
	endtask
	task automatic done(string nm);
		$display("Test %s done, errors %0d", nm, err_count);
	endtask
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog
	initial begin
		#(50 * 40000);
		err_count++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'hFE32));
		tick(6);
		reset <= 1'b0;
		wait_ready();
		rd("cor", OFS_CONFIG_OPT, RESET_BYTE);
		chk("mem_only", memory_only_pinout, 1'b1);
		rd("prr", OFS_PIN_REPLACE, 8'h22);
		rd("io_event", OFS_IO_EVENT, RESET_BYTE);
		hard_pin = 1'b1;
		op(1'b0, OFS_SOCKET_COPY, 8'h00);
		chk("core_reset", core_reset, 1'b1);
		hard_pin = 1'b0;
		op(1'b0, OFS_SOCKET_COPY, 8'h00);
		wait_ready();
		done("reset");
		wr(OFS_CONFIG_OPT, 8'h80);
		chk("core_reset", core_reset, 1'b1);
		chk("ready", link.ready, 1'b0);
		rd("cor", OFS_CONFIG_OPT, 8'h80);
		rises = 0;
		wr(OFS_CONFIG_OPT, 8'h00);
		wait_ready();
		chk("rises", rises != 0, 1'b1);
		rd("prr", OFS_PIN_REPLACE, 8'h22);
		wr(OFS_PIN_REPLACE, 8'h20);
		rd("prr", OFS_PIN_REPLACE, 8'h22);
		wr(OFS_PIN_REPLACE, 8'h02);
		rd("prr", OFS_PIN_REPLACE, 8'h02);
		done("soft_reset");
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom) & 8'h7F;
			if (i == 0) v[5:0] = 6'h00;
			wr(OFS_CONFIG_OPT, v);
			chk("level", level_irq_mode, v[6]);
			chk("index", config_index, v[5:0]);
			chk("mem_only", memory_only_pinout, v[5:0] == 6'h00);
			rd("cor", OFS_CONFIG_OPT, v);
			v = (i == 0) ? 8'hFF : 8'($urandom);
			wr(OFS_SOCKET_COPY, v);
			wr(OFS_SOCKET_COPY + 26'h1, ~v);
			wr(OFS_SOCKET_COPY & 26'h1FFFFFF, ~v);
			rd("scr", OFS_SOCKET_COPY, v);
			rd("odd", OFS_SOCKET_COPY + 26'h1, 8'h00);
		end
		axw(8'h0C, 32'h0, AXI_SLVERR);
		done("config");
		wr(OFS_CONFIG_OPT, 8'h01);
		wr(OFS_PIN_REPLACE, 8'h02);
		wr(OFS_CFG_STATUS, 8'h00);
		wr(OFS_IO_EVENT, 8'h01);
		wr(OFS_CFG_STATUS, 8'h40);
		ring();
		rd("io_event", OFS_IO_EVENT, 8'h11);
		rd("csr", OFS_CFG_STATUS, 8'hC0);
		chk("stat", {word[STAT_NRDY_BIT], word[STAT_CHG_BIT]}, 2'h1);
		chk("sts", link.stschg_n, sts_n(0, 1, 1, 1, 1));
		wr(OFS_CONFIG_OPT, 8'h00);
		chk("sts", link.stschg_n, sts_n(0, 1, 1, 0, 1));
		wr(OFS_CFG_STATUS, 8'h80);
		wr(OFS_CONFIG_OPT, 8'h01);
		chk("sts", link.stschg_n, sts_n(0, 0, 1, 1, 1));
		wr(OFS_IO_EVENT, 8'h00);
		wr(OFS_CFG_STATUS, 8'h40);
		chk("sts", link.stschg_n, sts_n(0, 1, 0, 1, 1));
		ring();
		rd("io_event", OFS_IO_EVENT, 8'h10);
		rd("csr", OFS_CFG_STATUS, 8'h40);
		done("bell");
		wr(OFS_CFG_STATUS, 8'h10);
		for (int i = 0; i < 6; i++) begin
			bell_n <= (i == 0) ? 1'b0 : 1'($urandom);
			tick(8);
			chk("sts", link.stschg_n, sts_n(1, 0, 0, 1, bell_n));
		end
		bell_n <= 1'b1;
		wr(OFS_CFG_STATUS, 8'h00);
		low_power_on <= 1'b1;
		osc_halt <= 1'($urandom);
		wr(OFS_CFG_STATUS, 8'h04);
		chk("gated", clocks_gated, 1'b1);
		chk("osc", oscillator_stop, osc_halt);
		wr(OFS_CFG_STATUS, 8'h00);
		chk("gated", clocks_gated, 1'b0);
		wr(OFS_CFG_STATUS, 8'h04);
		ring();
		chk("gated", clocks_gated, 1'b0);
		op(1'b0, OFS_CFG_STATUS, 8'h00);
		chk("pwr", q[CSR_LOW_POWER], 1'b0);
		done("route_power");
		irq_pending <= 1'b1;
		tick(8);
		chk("ireq", link.ireq_n, 1'b1);
		wr(OFS_CONFIG_OPT, 8'h41);
		chk("ireq", link.ireq_n, 1'b0);
		wr(OFS_CFG_STATUS, 8'h00);
		op(1'b0, OFS_CFG_STATUS, 8'h00);
		chk("intr", q[CSR_IRQ], 1'b1);
		irq_pending <= 1'b0;
		tick(8);
		op(1'b0, OFS_CFG_STATUS, 8'h00);
		chk("intr", q[CSR_IRQ], 1'b0);
		done("irq");
		report_and_stop();
	end
endmodule
